// file: logic/rts_pkg.sv
// Behaviour
// - power-up delay of 64 ms runs only after power-on or brown-out reset.
// - power-up delay counts the 31 kHz tick; chip reset held while it runs.
// - powerup_delay_disable high skips the power-up delay, low enables it.
// - watchdog and Timer0 share one 8-bit prescaler.
// - watchdog period selectable from about 17 ms to 2.2 s.
// - watchdog counts a 31 kHz time base.
// - watchdog held cleared during oscillator start-up count, then runs if enabled.
// - watchdog_enable_cfg high makes the watchdog run continuously.
// - prescaler_assign and prescale_select set the watchdog period.
// - watchdog cleared when disabled, on clear instruction, on non-crystal sleep exit.
// - on crystal-mode sleep exit watchdog held cleared until start-up count ends.
// - brown-out enable field: 11 always, 10 except sleep, 0X disabled.
// - brown-out during power-up delay restarts it; full delay after recovery.
// - during flash erase brown-out reset is forced on at lowest threshold.
// - power-up delay starts after power-on reset, start-up count after delay.
// - delays run regardless of reset pin; late pin release starts immediately.
// - external clock mode with delay disabled has no start-up time-out.
// - crystal modes add 1024 oscillator cycles after delay and on wake; low-power crystal only while the timer1 oscillator is off.
// - control bit 0 is brown-out flag, cleared by hardware, set by software.
// - control bit 1 is power-on flag, cleared on power-on only; software sets it.
// - timeout and powerdown flags set per reset cause.
//
// shared constants, types and register map of the reset sequencer
// assumes one 50 MHz clock and a plain one-cycle register port
package rts_pkg;
  localparam int CLOCK_HZ       = 50_000_000;
  localparam int LFOSC_HZ       = 31_000;
  localparam int LF_DIV         = CLOCK_HZ / LFOSC_HZ;
  localparam int POWERUP_DELAY_TIMER_MS        = 64;
  localparam int POWERUP_DELAY_TIMER_TICKS     = (POWERUP_DELAY_TIMER_MS * LFOSC_HZ) / 1000;
  localparam int WDT_BASE_MS    = 17;
  localparam int WDT_BASE_TICKS = (WDT_BASE_MS * LFOSC_HZ) / 1000;
  localparam int OST_CYCLES     = 1024;
  localparam int PRESCALE_W     = 8;

  localparam logic [1:0] BOR_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_AWAKE  = 2'h2;

  localparam logic [1:0] REG_POWER_CONTROL = 2'h0;
  localparam logic [1:0] REG_OPTION        = 2'h1;
  localparam logic [1:0] REG_RESET_STATUS  = 2'h2;

  localparam int POWER_CONTROL_STATUS_BOR_BIT = 0;
  localparam int POWER_CONTROL_STATUS_POR_BIT = 1;
  localparam int OPT_PS_LSB   = 0;
  localparam int OPT_PS_MSB   = 2;
  localparam int OPT_PSA_BIT  = 3;
  localparam int STAT_PD_BIT  = 0;
  localparam int STAT_TO_BIT  = 1;

  localparam logic [7:0] OPTION_RESET = 8'hFF;

  typedef enum logic [2:0] {
    OSC_CRYSTAL_LOWPOWER,
    OSC_CRYSTAL_MEDIUM,
    OSC_CRYSTAL_FAST,
    OSC_RESISTOR_CAP,
    OSC_INTERNAL,
    OSC_EXT_CLOCK
  } rts_osc_t;

  typedef struct packed {
    logic       powerup_delay_disable;
    logic       watchdog_enable_cfg;
    logic [1:0] brownout_enable_cfg;
    rts_osc_t   osc_mode;
  } rts_cfg_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rts_bus_t;
endpackage

// file: logic/rts_sequencer.sv
// reset, start-up timer and watchdog sequencer with its status registers
// assumes supply detectors, config bits and cpu events are synchronous to CLOCK
`timescale 1ns/10ps
module rts_sequencer #(
  parameter int LF_DIV_P     = rts_pkg::LF_DIV,
  parameter int POWERUP_DELAY_TIMER_TICKS_P = rts_pkg::POWERUP_DELAY_TIMER_TICKS,
  parameter int WDT_BASE_P   = rts_pkg::WDT_BASE_TICKS,
  parameter int OST_CYCLES_P = rts_pkg::OST_CYCLES
) (
  input  wire logic              CLOCK,
  input  wire logic              RSTN,
  input  wire rts_pkg::rts_cfg_t CFG,
  input  wire logic              POWERON_RESET,
  input  wire logic              BELOW_BROWNOUT,
  input  wire logic              BELOW_BROWNOUT_MIN,
  input  wire logic              FLASH_ERASE,
  input  wire logic              EXT_RESET_N,
  input  wire logic              TIMER1_OSC_EN,
  input  wire logic              OSC_TICK,
  input  wire logic              TMR0_TICK,
  input  wire logic              SLEEP_ENTER,
  input  wire logic              WAKE,
  input  wire logic              WDT_CLEAR,
  input  wire rts_pkg::rts_bus_t BUS,
  output logic [7:0]             RDATA,
  output logic                   CHIP_RESET,
  output logic                   SLEEPING,
  output logic                   WDT_WAKE,
  output logic                   TMR0_PRESCALED
);
  localparam int LF_W  = $clog2(LF_DIV_P + 1);
  localparam int WB_W  = $clog2(WDT_BASE_P + 1);
  localparam int SEQ_W = $clog2((POWERUP_DELAY_TIMER_TICKS_P > OST_CYCLES_P ? POWERUP_DELAY_TIMER_TICKS_P : OST_CYCLES_P) + 1);
  localparam int PW    = rts_pkg::PRESCALE_W;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_POWERUP_DELAY_TIMER,
    ST_OST,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_OST
  } rts_state_t;

  rts_state_t       state;
  rts_state_t       next_state;
  logic [LF_W-1:0]  lf_cnt;
  logic             lf_tick;
  logic [SEQ_W-1:0] seq_cnt;
  logic [WB_W-1:0]  wdt_base;
  logic [PW-1:0]    pre;
  logic [7:0]       option;
  logic             power_control_status_bor;
  logic             power_control_status_por;
  logic             timeout_flag;
  logic             powerdown_flag;
  logic             wdt_rst;
  logic             bor_en;
  logic             bor_trip;
  logic             hard;
  logic             ost_needed;
  logic             powerup_delay_timer_done;
  logic             ost_done;
  logic             wdt_clear_src;
  logic             base_ovf;
  logic             wdt_timeout;
  logic             prescaler_assign;
  logic [2:0]       ps;
  logic [PW-1:0]    wdt_mask;
  logic [PW-1:0]    tmr_mask;
  logic             next_chip_reset;

  // prescale mask: watchdog divides by 2^ps, Timer0 by 2^(ps+1)
  function automatic logic [PW-1:0] ps_mask(input logic [2:0] sel, input logic for_timer);
    logic [PW-1:0] one;
    one = for_timer ? PW'(2) : PW'(1);
    return (one << sel) - PW'(1);
  endfunction

  function automatic logic bor_decode(input logic [1:0] field, input logic asleep);
    return (field == rts_pkg::BOR_ALWAYS) || (field == rts_pkg::BOR_AWAKE && !asleep);
  endfunction

  assign prescaler_assign      = option[rts_pkg::OPT_PSA_BIT];
  assign ps       = option[rts_pkg::OPT_PS_MSB:rts_pkg::OPT_PS_LSB];
  assign wdt_mask = ps_mask(ps, 1'b0);
  assign tmr_mask = ps_mask(ps, 1'b1);

  assign bor_en   = bor_decode(CFG.brownout_enable_cfg, state == ST_SLEEP);
  // erase uses the lowest trip point so protection logic sees a valid supply
  assign bor_trip = FLASH_ERASE ? BELOW_BROWNOUT_MIN : (bor_en && BELOW_BROWNOUT);
  assign hard     = POWERON_RESET || bor_trip;

  // low-power crystal counts start-up only while the timer1 side oscillator is off
  assign ost_needed = (CFG.osc_mode == rts_pkg::OSC_CRYSTAL_MEDIUM) ||
                      (CFG.osc_mode == rts_pkg::OSC_CRYSTAL_FAST) ||
                      (CFG.osc_mode == rts_pkg::OSC_CRYSTAL_LOWPOWER && !TIMER1_OSC_EN);

  // 31 kHz time base derived from the system clock
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      lf_cnt <= '0;
    end else if (lf_cnt == LF_W'(LF_DIV_P - 1)) begin
      lf_cnt <= '0;
    end else begin
      lf_cnt <= lf_cnt + LF_W'(1);
    end
  end
  assign lf_tick = (lf_cnt == LF_W'(LF_DIV_P - 1));

  assign powerup_delay_timer_done = lf_tick && seq_cnt == SEQ_W'(POWERUP_DELAY_TIMER_TICKS_P - 1);
  assign ost_done  = OSC_TICK && seq_cnt == SEQ_W'(OST_CYCLES_P - 1);

  // the sequence ignores the reset pin so a late release starts at once
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (!CFG.powerup_delay_disable) begin
          next_state = ST_POWERUP_DELAY_TIMER;
        end else if (ost_needed) begin
          next_state = ST_OST;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_POWERUP_DELAY_TIMER: begin
        if (powerup_delay_timer_done) begin
          next_state = ost_needed ? ST_OST : ST_RUN;
        end
      end
      ST_OST, ST_WAKE_OST: begin
        if (ost_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (SLEEP_ENTER && EXT_RESET_N && !wdt_timeout) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!EXT_RESET_N) begin
          next_state = ST_RUN;
        end else if (WAKE || wdt_timeout) begin
          next_state = ost_needed ? ST_WAKE_OST : ST_RUN;
        end
      end
      default: next_state = ST_HOLD;
    endcase
    if (hard) begin
      next_state = ST_HOLD;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // one counter serves both delay stages, restarted on every state change
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      seq_cnt <= '0;
    end else if (next_state != state || state == ST_HOLD) begin
      seq_cnt <= '0;
    end else if ((state == ST_POWERUP_DELAY_TIMER && lf_tick) ||
                 ((state == ST_OST || state == ST_WAKE_OST) && OSC_TICK)) begin
      seq_cnt <= seq_cnt + SEQ_W'(1);
    end
  end

  // watchdog is held while the start-up counter borrows its chain
  // sleep exit is taken from the wake request and pin, not next_state, so a timeout cannot gate its own clear
  assign wdt_clear_src = !CFG.watchdog_enable_cfg || WDT_CLEAR ||
                         state == ST_HOLD || state == ST_POWERUP_DELAY_TIMER ||
                         state == ST_OST || state == ST_WAKE_OST ||
                         (state == ST_SLEEP && (WAKE || !EXT_RESET_N));
  assign base_ovf    = lf_tick && !wdt_clear_src && wdt_base == WB_W'(WDT_BASE_P - 1);
  assign wdt_timeout = base_ovf && (!prescaler_assign || (pre & wdt_mask) == wdt_mask);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wdt_base <= '0;
    end else if (wdt_clear_src || base_ovf) begin
      wdt_base <= '0;
    end else if (lf_tick) begin
      wdt_base <= wdt_base + WB_W'(1);
    end
  end

  // single prescaler: follows the watchdog or Timer0 as assigned
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pre <= '0;
    end else if (BUS.wr && BUS.addr == rts_pkg::REG_OPTION &&
                 BUS.wdata[rts_pkg::OPT_PSA_BIT] != prescaler_assign) begin
      pre <= '0;
    end else if (prescaler_assign) begin
      if (wdt_clear_src || wdt_timeout) begin
        pre <= '0;
      end else if (base_ovf) begin
        pre <= pre + PW'(1);
      end
    end else if (TMR0_TICK) begin
      pre <= pre + PW'(1);
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      TMR0_PRESCALED <= 1'b0;
    end else begin
      TMR0_PRESCALED <= !prescaler_assign && TMR0_TICK && (pre & tmr_mask) == tmr_mask;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wdt_rst  <= 1'b0;
      WDT_WAKE <= 1'b0;
    end else begin
      wdt_rst  <= state == ST_RUN && wdt_timeout && !hard;
      WDT_WAKE <= state == ST_SLEEP && wdt_timeout && !hard && EXT_RESET_N;
    end
  end

  assign next_chip_reset = next_state == ST_HOLD || next_state == ST_POWERUP_DELAY_TIMER ||
                           next_state == ST_OST || !EXT_RESET_N ||
                           (state == ST_RUN && wdt_timeout);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      CHIP_RESET <= 1'b1;
      SLEEPING   <= 1'b0;
    end else begin
      CHIP_RESET <= next_chip_reset;
      SLEEPING   <= next_state == ST_SLEEP;
    end
  end

  // option register returns to all ones on every chip reset, not on wake
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      option <= rts_pkg::OPTION_RESET;
    end else if (CHIP_RESET) begin
      option <= rts_pkg::OPTION_RESET;
    end else if (BUS.wr && BUS.addr == rts_pkg::REG_OPTION) begin
      option <= BUS.wdata;
    end
  end

  // hardware clears win over a software write in the same cycle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      power_control_status_bor <= 1'b0;
      power_control_status_por <= 1'b0;
    end else begin
      if (bor_trip && !POWERON_RESET) begin
        power_control_status_bor <= 1'b0;
      end else if (BUS.wr && BUS.addr == rts_pkg::REG_POWER_CONTROL) begin
        power_control_status_bor <= BUS.wdata[rts_pkg::POWER_CONTROL_STATUS_BOR_BIT];
      end
      if (POWERON_RESET) begin
        power_control_status_por <= 1'b0;
      end else if (BUS.wr && BUS.addr == rts_pkg::REG_POWER_CONTROL) begin
        power_control_status_por <= BUS.wdata[rts_pkg::POWER_CONTROL_STATUS_POR_BIT];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (hard) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (state == ST_SLEEP && wdt_timeout && EXT_RESET_N) begin
      timeout_flag   <= 1'b0;
      powerdown_flag <= 1'b0;
    end else if (state == ST_RUN && wdt_timeout) begin
      timeout_flag   <= 1'b0;
    end else if (state == ST_SLEEP && !EXT_RESET_N) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (WDT_CLEAR) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (state == ST_RUN && next_state == ST_SLEEP) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (BUS.rd) begin
      case (BUS.addr)
        rts_pkg::REG_POWER_CONTROL: RDATA <= {6'h00, power_control_status_por, power_control_status_bor};
        rts_pkg::REG_OPTION:        RDATA <= option;
        rts_pkg::REG_RESET_STATUS:  RDATA <= {6'h00, timeout_flag, powerdown_flag};
        default:                    RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  sequence s_trip_in_delay;
    state == ST_POWERUP_DELAY_TIMER && bor_trip;
  endsequence
  sequence s_recovered_hold;
    state == ST_HOLD && !hard && !CFG.powerup_delay_disable;
  endsequence

  AST_DELAY_ONLY_FROM_HARD: assert property ($rose(state == ST_POWERUP_DELAY_TIMER) |-> $past(state) == ST_HOLD)
    else $error("power-up delay entered without hard reset");
  AST_RESET_DURING_DELAY: assert property (state == ST_POWERUP_DELAY_TIMER && next_state == ST_POWERUP_DELAY_TIMER |=> CHIP_RESET)
    else $error("chip reset not held during power-up delay");
  AST_DELAY_DISABLED: assert property (state == ST_HOLD && CFG.powerup_delay_disable |=> state != ST_POWERUP_DELAY_TIMER)
    else $error("disabled power-up delay ran");
  AST_WDT_HELD_IN_OST: assert property ((state == ST_OST || state == ST_WAKE_OST) |=> wdt_base == '0)
    else $error("watchdog counted during start-up count");
  AST_WDT_OFF_CLEARS: assert property (!CFG.watchdog_enable_cfg |=> wdt_base == '0 && !WDT_WAKE)
    else $error("disabled watchdog not cleared");
  AST_BROWNOUT_RESTART: assert property (s_trip_in_delay |=> state == ST_HOLD)
    else $error("brown-out did not restart delay");
  AST_FULL_DELAY: assert property (s_recovered_hold |=> state == ST_POWERUP_DELAY_TIMER && seq_cnt == '0)
    else $error("power-up delay not restarted from zero");
  AST_OST_LENGTH: assert property ($fell(state == ST_OST) && state == ST_RUN |->
                                   $past(seq_cnt) == SEQ_W'(OST_CYCLES_P - 1) && $past(OSC_TICK))
    else $error("start-up count ended early");
  AST_NO_TIMEOUT_EXT_CLOCK: assert property (state == ST_HOLD && !hard && CFG.powerup_delay_disable &&
                                             CFG.osc_mode == rts_pkg::OSC_EXT_CLOCK |=> state == ST_RUN)
    else $error("external clock with delay off took a time-out");
  AST_POWERON_FLAGS: assert property (POWERON_RESET |=> !power_control_status_por && timeout_flag && powerdown_flag)
    else $error("power-on flags wrong");
  AST_BROWNOUT_FLAG: assert property (bor_trip && !POWERON_RESET |=> !power_control_status_bor && timeout_flag)
    else $error("brown-out flag not cleared");
  AST_WDT_WAKE_FLAGS: assert property (WDT_WAKE |-> !timeout_flag && !powerdown_flag)
    else $error("watchdog wake flags wrong");
  AST_RELEASE: assert property ($fell(CHIP_RESET) |-> $past(EXT_RESET_N) &&
                                (state == ST_RUN || state == ST_SLEEP || state == ST_WAKE_OST))
    else $error("chip reset released early");
  AST_ERASE_FORCES_BOR: assert property (FLASH_ERASE && BELOW_BROWNOUT_MIN |=> state == ST_HOLD)
    else $error("flash erase brown-out not forced");

  // wake paths, clears and reset-cause flags
  AST_SLEEP_EXIT_CLEARS: assert property (state == ST_SLEEP && WAKE && EXT_RESET_N |=> wdt_base == '0)
    else $error("watchdog not cleared on wake");
  AST_CLEAR_INSTR: assert property (WDT_CLEAR |=> wdt_base == '0)
    else $error("clear instruction did not clear watchdog");
  AST_WDT_COUNTS: assert property (state == ST_RUN && CFG.watchdog_enable_cfg && !WDT_CLEAR &&
                                   lf_tick && !base_ovf |=> wdt_base == $past(wdt_base) + WB_W'(1))
    else $error("enabled watchdog did not count");
  AST_WAKE_OST: assert property (state == ST_SLEEP && (WAKE || wdt_timeout) && EXT_RESET_N &&
                                 !hard && ost_needed |=> state == ST_WAKE_OST)
    else $error("crystal wake skipped start-up count");
  AST_BOR_DISABLED: assert property (!CFG.brownout_enable_cfg[1] && !FLASH_ERASE |-> !bor_trip)
    else $error("disabled brown-out reset tripped");
  AST_POR_HOLDS: assert property (POWERON_RESET |=> CHIP_RESET && state == ST_HOLD)
    else $error("power-on reset did not hold the sequence");
  AST_WDT_RESET_PULSE: assert property (wdt_rst |-> CHIP_RESET && !timeout_flag)
    else $error("watchdog reset flags wrong");
  AST_EXT_SLEEP_FLAGS: assert property (state == ST_SLEEP && !EXT_RESET_N && !hard |=>
                                        timeout_flag && !powerdown_flag)
    else $error("reset pin in sleep flags wrong");
  AST_OPTION_RESET: assert property (CHIP_RESET |=> option == rts_pkg::OPTION_RESET)
    else $error("option register not reset");
endmodule

// file: tb/reset_timeout_sequencer_tb_top.sv
// self-checking bench for the reset sequencer: register port, start-up delays, watchdog, brown-out
// assumes registered outputs settle well within 1 ns of the rising edge; short counts via parameters
`timescale 1ns/10ps
module reset_timeout_sequencer_tb_top;
  localparam int L  = 4;
  localparam int P  = 8;
  localparam int W  = 4;
  localparam int O  = 8;
  // osc tick pulses every other cycle, so the start-up count takes two cycles per tick
  localparam int PU = P * L + 2 * O;
  logic              clk;
  logic              rstn;
  rts_pkg::rts_cfg_t cfg;
  rts_pkg::rts_bus_t bus;
  logic              por, bb, bbm, fe, ext_n, t1en, osc, tm0, slp, wake, wclr;
  logic [7:0]        rdata;
  logic              chip_rst, sleeping, wdt_wake, tm0_pre;
  int                failures, cmp_count, pcnt, n, k;
  logic [7:0]        d;

  rts_sequencer #(.LF_DIV_P(L), .POWERUP_DELAY_TIMER_TICKS_P(P), .WDT_BASE_P(W), .OST_CYCLES_P(O)) DUT (
    .CLOCK(clk), .RSTN(rstn), .CFG(cfg), .POWERON_RESET(por), .BELOW_BROWNOUT(bb),
    .BELOW_BROWNOUT_MIN(bbm), .FLASH_ERASE(fe), .EXT_RESET_N(ext_n), .TIMER1_OSC_EN(t1en),
    .OSC_TICK(osc), .TMR0_TICK(tm0), .SLEEP_ENTER(slp), .WAKE(wake), .WDT_CLEAR(wclr),
    .BUS(bus), .RDATA(rdata), .CHIP_RESET(chip_rst), .SLEEPING(sleeping), .WDT_WAKE(wdt_wake),
    .TMR0_PRESCALED(tm0_pre));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) osc <= ~osc;
  always @(posedge clk) if (tm0_pre === 1'b1) pcnt <= pcnt + 1;

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic cmp_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t ns: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t ns: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    bus.addr  <= a;
    bus.wdata <= v;
    bus.wr    <= 1'b1;
    tick;
    bus.wr    <= 1'b0;
    tick;
  endtask

  // read data stand only in the cycle after the strobe, so they are taken right then
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    tick;
    v = rdata;
    bus.rd   <= 1'b0;
    tick;
  endtask

  task automatic wait_rst(input logic lvl, input int max);
    n = 0;
    while (chip_rst !== lvl && n < max) begin
      tick;
      n++;
    end
  endtask

  task automatic in_range(input int lo, input int hi);
    cmp_bit(n >= lo && n <= hi, 1'b1);
  endtask

  task automatic count_high(input int cycles);
    n = 0;
    repeat (cycles) begin
      tick;
      if (chip_rst !== 1'b0) n++;
    end
  endtask

  task automatic power_on;
    por <= 1'b1;
    repeat (3) tick;
    por <= 1'b0;
  endtask

  task automatic report_and_stop;
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end

  initial begin
    rstn = 1'b0;
    cfg = '{powerup_delay_disable: 1'b0, watchdog_enable_cfg: 1'b0, brownout_enable_cfg: 2'h0,
            osc_mode: rts_pkg::OSC_CRYSTAL_MEDIUM};
    bus = '0;
    {por, bb, bbm, fe, t1en, osc, tm0, slp, wake, wclr} = '0;
    ext_n = 1'b1;
    failures = 0;
    cmp_count = 0;
    pcnt = 0;
    repeat (16) @(posedge clk);
    #1 rstn <= 1'b1;
    wait_rst(1'b0, 200);
    in_range(PU - L - 2, PU + L + 6);
    rd(2'h0, d); cmp_byte(d, 8'h00);
    rd(2'h2, d); cmp_byte(d, 8'h03);
    rd(2'h1, d); cmp_byte(d, 8'hFF);
    rd(2'h3, d); cmp_byte(d, 8'h00);
    wr(2'h0, 8'h03); rd(2'h0, d); cmp_byte(d, 8'h03);
    wr(2'h2, 8'h00); rd(2'h2, d); cmp_byte(d, 8'h03);
    // prescaler on timer0, select 0: one output per two input ticks
    wr(2'h1, 8'h00);
    k = pcnt;
    tm0 <= 1'b1;
    repeat (40) tick;
    tm0 <= 1'b0;
    tick;
    cmp_bit(pcnt - k >= 19 && pcnt - k <= 21, 1'b1);
    // prescaler on watchdog, select 1: period of two base counts
    wr(2'h1, 8'h09);
    cfg.watchdog_enable_cfg <= 1'b1;
    repeat (5) begin
      wclr <= 1'b1; tick; wclr <= 1'b0;
      count_high(19); cmp_bit(n == 0, 1'b1);
    end
    wclr <= 1'b1; tick; wclr <= 1'b0;
    wait_rst(1'b1, 80);
    in_range(2 * W * L - L - 3, 2 * W * L + L + 6);
    wait_rst(1'b0, 5); in_range(0, 2);
    cfg.watchdog_enable_cfg <= 1'b0;
    tick;
    rd(2'h2, d); cmp_byte(d, 8'h01);
    rd(2'h0, d); cmp_byte(d, 8'h03);
    count_high(200); cmp_bit(n == 0, 1'b1);
    // watchdog wakes the device from sleep
    wr(2'h1, 8'h08);
    cfg.watchdog_enable_cfg <= 1'b1;
    slp <= 1'b1; tick; slp <= 1'b0; tick;
    cmp_bit(sleeping, 1'b1);
    rd(2'h2, d); cmp_byte(d, 8'h02);
    n = 0;
    while (wdt_wake !== 1'b1 && n < 60) begin
      tick;
      n++;
    end
    cmp_bit(wdt_wake, 1'b1);
    cfg.watchdog_enable_cfg <= 1'b0;
    rd(2'h2, d); cmp_byte(d, 8'h00);
    repeat (30) tick;
    // external reset while asleep
    slp <= 1'b1; tick; slp <= 1'b0; ext_n <= 1'b0;
    repeat (3) tick;
    cmp_bit(chip_rst, 1'b1);
    ext_n <= 1'b1;
    wait_rst(1'b0, 5); in_range(0, 3);
    rd(2'h2, d); cmp_byte(d, 8'h02);
    // every brown-out enable code, awake
    for (int c = 0; c < 4; c++) begin
      cfg.brownout_enable_cfg <= c[1:0];
      tick;
      bb <= 1'b1;
      count_high(6);
      bb <= 1'b0;
      cmp_bit(n > 0, c[1]);
      wait_rst(1'b0, 200);
    end
    // second dip during the delay restarts it
    wr(2'h0, 8'h03);
    bb <= 1'b1; repeat (3) tick; bb <= 1'b0; repeat (10) tick;
    bb <= 1'b1; repeat (3) tick; bb <= 1'b0;
    wait_rst(1'b0, 200); in_range(PU - L - 2, PU + L + 6);
    rd(2'h0, d); cmp_byte(d, 8'h02);
    rd(2'h2, d); cmp_byte(d, 8'h03);
    // flash erase forces the lowest trip point even with brown-out off
    cfg.brownout_enable_cfg <= 2'h0;
    fe <= 1'b1; bbm <= 1'b1;
    count_high(6); cmp_bit(n > 0, 1'b1);
    fe <= 1'b0; bbm <= 1'b0;
    wait_rst(1'b0, 200);
    // pin held low through the delays, then released
    ext_n <= 1'b0;
    power_on;
    wr(2'h1, 8'h00);
    repeat (PU + L + 10) tick;
    cmp_bit(chip_rst, 1'b1);
    ext_n <= 1'b1;
    wait_rst(1'b0, 5); in_range(0, 2);
    rd(2'h1, d); cmp_byte(d, 8'hFF);
    rd(2'h0, d); cmp_bit(d[1], 1'b0);
    // external clock: no delay when disabled, delay only when enabled
    cfg.osc_mode <= rts_pkg::OSC_EXT_CLOCK;
    cfg.powerup_delay_disable <= 1'b1;
    power_on;
    wait_rst(1'b0, 10); in_range(0, 3);
    cfg.powerup_delay_disable <= 1'b0;
    power_on;
    wait_rst(1'b0, 100); in_range(P * L - L - 2, P * L + L + 6);
    // low-power crystal with the side oscillator on: delay only, interrupt wake goes straight to run
    cfg.osc_mode <= rts_pkg::OSC_CRYSTAL_LOWPOWER;
    t1en <= 1'b1;
    power_on;
    wait_rst(1'b0, 100); in_range(P * L - L - 2, P * L + L + 6);
    slp <= 1'b1; tick; slp <= 1'b0; wake <= 1'b1;
    cmp_bit(sleeping, 1'b1);
    tick; wake <= 1'b0; tick;
    cmp_bit(sleeping, 1'b0);
    cmp_bit(chip_rst, 1'b0);
    rd(2'h2, d); cmp_byte(d, 8'h02);
    report_and_stop;
  end
endmodule
